// File: mac_engine.sv
// Purpose: Signed 16x16 multiply-accumulate engine with 40-bit accumulator
// Assumes: Byte registers on a plain port, read data one cycle after strobe
// Notes: CE low freezes every flip-flop
`timescale 1ns/100ps
`default_nettype none
module mac_engine (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire mac_pkg::mac_addr_t ADDR,
    input wire mac_pkg::mac_byte_t WDATA,
    input wire logic WR,
    input wire logic RD,
    output mac_pkg::mac_byte_t RDATA
);
    import mac_pkg::*;

    mac_cfg_t cfg_q;
    mac_flags_t flags_q;
    mac_word_t op1_q;
    mac_word_t op2_q;
    mac_acc_t acc_q;
    mac_acc_t prod_q;
    mac_word_t rnd_q;
    mac_byte_t rdata_q;
    logic start_q;
    logic s2_v_q;
    logic s2_ms_q;
    logic s3_v_q;
    logic shift_ph_q;
    logic rnd_req_q;

    logic wr_cfg;
    logic wr_flags;
    logic wr_start;
    logic [ACC_BYTES-1:0] wr_acc;
    mac_acc_t acc_wr_d;
    mac_acc_t acc_sum;
    mac_acc_t prod_d;
    logic signed [PROD_W-1:0] prod_raw;
    logic clr_now;
    logic shift_do;
    logic shift_rnd;
    logic hard_ov;
    logic soft_ov;
    mac_word_t rnd_val;
    mac_byte_t rd_mux;

    // Address decode
    assign wr_cfg = WR && (ADDR == A_CFG);
    assign wr_flags = WR && (ADDR == A_FLAGS);
    assign wr_start = WR && (ADDR == A_OP2_LO);

    for (genvar i = 0; i < ACC_BYTES; i++) begin : g_acc_byte
        assign wr_acc[i] = WR && (ADDR == mac_addr_t'(A_ACC0 - i));
        assign acc_wr_d[i*BYTE_W +: BYTE_W] = wr_acc[i] ? WDATA : acc_q[i*BYTE_W +: BYTE_W];
    end

    assign prod_raw = PROD_W'($signed(op1_q)) * PROD_W'($signed(op2_q));
    always_comb begin
        prod_d = {{(ACC_W-PROD_W){prod_raw[PROD_W-1]}}, prod_raw};
        if (cfg_q.fractional_format_sel) begin
            prod_d = {prod_d[ACC_W-2:0], 1'b0};
        end
    end

    assign clr_now = start_q && cfg_q.clear_accumulator;
    assign acc_sum = (s2_ms_q ? '0 : acc_q) + prod_q;
    assign hard_ov = ((acc_q[ACC_W-1:TOP_LO] == TOP_POS) && (acc_sum[ACC_W-1:TOP_LO] == TOP_NEG))
        || ((acc_q[ACC_W-1:TOP_LO] == TOP_NEG) && (acc_sum[ACC_W-1:TOP_LO] == TOP_POS));
    assign soft_ov = !((&acc_sum[ACC_W-1:SIGN_LO]) || !(|acc_sum[ACC_W-1:SIGN_LO]));

    assign shift_do = cfg_q.shift_go && !shift_ph_q;
    assign shift_rnd = cfg_q.shift_go && shift_ph_q;

    mac_round u_round (
        .acc(acc_q),
        .sat_en(cfg_q.saturate_enable),
        .rnd(rnd_val)
    );

    // Operand registers
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            op1_q <= '0;
            op2_q <= '0;
        end else if (CE && WR) begin
            if (ADDR == A_OP1_HI) op1_q[OP_W-1:BYTE_W] <= WDATA;
            if (ADDR == A_OP1_LO) op1_q[BYTE_W-1:0] <= WDATA;
            if (ADDR == A_OP2_HI) op2_q[OP_W-1:BYTE_W] <= WDATA;
            if (ADDR == A_OP2_LO) op2_q[BYTE_W-1:0] <= WDATA;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            start_q <= 1'b0;
            s2_v_q <= 1'b0;
            s2_ms_q <= 1'b0;
            s3_v_q <= 1'b0;
            prod_q <= '0;
        end else if (CE) begin
            start_q <= wr_start;
            s2_v_q <= start_q;
            s3_v_q <= s2_v_q;
            if (start_q) begin
                prod_q <= prod_d;
                s2_ms_q <= cfg_q.multiply_only_sel;
            end
        end
    end

    // Configuration and self-clearing bits
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q <= mac_cfg_t'(CFG_RST);
        end else if (CE) begin
            if (clr_now) cfg_q.clear_accumulator <= 1'b0;
            if (shift_rnd) cfg_q.shift_go <= 1'b0;
            if (wr_cfg) cfg_q <= mac_cfg_t'(WDATA & CFG_WMASK);
        end
    end

    // Shift phase tracking
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            shift_ph_q <= 1'b0;
        end else if (CE) begin
            if (wr_cfg) shift_ph_q <= 1'b0;
            else if (shift_do) shift_ph_q <= 1'b1;
            else if (shift_rnd) shift_ph_q <= 1'b0;
        end
    end

    // Accumulator
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            acc_q <= '0;
        end else if (CE) begin
            if (clr_now) begin
                acc_q <= '0;
            end else if (s2_v_q) begin
                acc_q <= acc_sum;
            end else if (shift_do) begin
                if (cfg_q.shift_direction) acc_q <= {acc_q[ACC_W-1], acc_q[ACC_W-1:1]};
                else acc_q <= {acc_q[ACC_W-2:0], 1'b0};
            end else begin
                acc_q <= acc_wr_d;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flags_q <= mac_flags_t'(FLAGS_RST);
        end else if (CE) begin
            if (clr_now) begin
                flags_q <= '0;
            end else begin
                if (wr_flags) flags_q <= mac_flags_t'(WDATA & FLAGS_WMASK);
                if (s2_v_q) begin
                    flags_q.negative_flag <= acc_sum[ACC_W-1];
                    flags_q.zero_flag <= (acc_sum == '0);
                    flags_q.soft_overflow_flag <= soft_ov;
                    if (!s2_ms_q && hard_ov) flags_q.hard_overflow_flag <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rnd_req_q <= 1'b0;
        end else if (CE) begin
            rnd_req_q <= wr_acc[0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rnd_q <= '0;
        end else if (CE) begin
            if (s3_v_q || shift_rnd || rnd_req_q) rnd_q <= rnd_val;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_mux = '0;
        unique case (ADDR)
            A_CFG: rd_mux = cfg_q;
            A_FLAGS: rd_mux = flags_q;
            A_OP1_HI: rd_mux = op1_q[OP_W-1:BYTE_W];
            A_OP1_LO: rd_mux = op1_q[BYTE_W-1:0];
            A_OP2_HI: rd_mux = op2_q[OP_W-1:BYTE_W];
            A_OP2_LO: rd_mux = op2_q[BYTE_W-1:0];
            A_RND_HI: rd_mux = rnd_q[OP_W-1:BYTE_W];
            A_RND_LO: rd_mux = rnd_q[BYTE_W-1:0];
            default: begin
                for (int k = 0; k < ACC_BYTES; k++) begin
                    if (ADDR == mac_addr_t'(A_ACC0 - k)) rd_mux = acc_q[k*BYTE_W +: BYTE_W];
                end
            end
        endcase
    end

    // Read data one cycle later
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q <= '0;
        end else if (CE) begin
            rdata_q <= RD ? rd_mux : '0;
        end
    end

    assign RDATA = rdata_q;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN || !CE);

    a_pipe_three_stage: assert property (
        wr_start |=> start_q ##1 s2_v_q ##1 s3_v_q)
        else $error("pipeline stage timing broken");

    a_mac_accumulate: assert property (
        s2_v_q && !s2_ms_q && !clr_now |=> acc_q == mac_acc_t'($past(acc_q) + $past(prod_q)))
        else $error("accumulate result wrong");

    a_mult_only_load: assert property (
        wr_start && cfg_q.multiply_only_sel && !cfg_q.clear_accumulator && !wr_cfg
        ##1 !wr_cfg ##1 !clr_now |=> acc_q == $past(prod_q))
        else $error("multiply-only result wrong");

    a_clear_acc_flags: assert property (
        clr_now && !wr_cfg |=> acc_q == '0 && flags_q == '0 && !cfg_q.clear_accumulator)
        else $error("clear did not zero state");

    a_hard_ov_kept: assert property (
        s2_v_q && s2_ms_q && !clr_now && !wr_flags
        |=> flags_q.hard_overflow_flag == $past(flags_q.hard_overflow_flag))
        else $error("hard overflow changed in multiply-only");

    a_shift_right_sign: assert property (
        shift_do && cfg_q.shift_direction && !s2_v_q && !clr_now
        |=> acc_q == {$past(acc_q[ACC_W-1]), $past(acc_q[ACC_W-1:1])})
        else $error("right shift fill wrong");

    a_shift_left_fill: assert property (
        shift_do && !cfg_q.shift_direction && !s2_v_q && !clr_now
        |=> acc_q == {$past(acc_q[ACC_W-2:0]), 1'b0})
        else $error("left shift result wrong");

    a_hard_ov_set: assert property (
        s2_v_q && !s2_ms_q && hard_ov && !clr_now |=> flags_q.hard_overflow_flag)
        else $error("hard overflow not set");

    a_shift_flags_stable: assert property (
        shift_do && !s2_v_q && !clr_now && !wr_flags |=> $stable(flags_q))
        else $error("shift altered flags");

    a_shift_round_done: assert property (
        (shift_do && !wr_cfg && !s2_v_q) ##1 !wr_cfg
        |=> !cfg_q.shift_go && rnd_q == $past(rnd_val))
        else $error("shift did not round and clear");

    a_round_stage_three: assert property (
        s3_v_q |=> rnd_q == $past(rnd_val))
        else $error("rounding register not updated");

    a_zero_flag_tracks: assert property (
        s2_v_q && !clr_now |=> flags_q.zero_flag == (acc_q == '0))
        else $error("zero flag mismatch");

    a_read_latency: assert property (
        RD |=> RDATA == $past(rd_mux))
        else $error("read data not one cycle later");

    c_back_to_back: cover property (wr_start ##2 wr_start);
    c_shift_round: cover property (shift_do ##1 shift_rnd);
    c_hard_overflow: cover property (s2_v_q && !s2_ms_q && hard_ov);
    c_saturate: cover property (s3_v_q && cfg_q.saturate_enable && soft_ov);

endmodule : mac_engine
`default_nettype wire

// File: mac_pkg.sv
// Purpose: Shared constants and types of the multiply-accumulate engine
// Assumes: Byte-wide register port, one system clock
// Notes: Register offsets are local choices of this block
package mac_pkg;

    // Data path widths
    localparam int OP_W = 16;
    localparam int ACC_W = 40;
    localparam int BYTE_W = 8;
    localparam int ACC_BYTES = 5;
    localparam int PROD_W = 32;
    localparam int RND_LO = 16;
    localparam int SIGN_LO = 31;
    localparam int TOP_LO = 32;

    typedef logic [3:0] mac_addr_t;
    typedef logic [BYTE_W-1:0] mac_byte_t;
    typedef logic [OP_W-1:0] mac_word_t;
    typedef logic [ACC_W-1:0] mac_acc_t;

    // Register offsets
    localparam mac_addr_t A_CFG = 4'h0;
    localparam mac_addr_t A_FLAGS = 4'h1;
    localparam mac_addr_t A_OP1_HI = 4'h2;
    localparam mac_addr_t A_OP1_LO = 4'h3;
    localparam mac_addr_t A_OP2_HI = 4'h4;
    localparam mac_addr_t A_OP2_LO = 4'h5;
    localparam mac_addr_t A_ACC_TOP = 4'h6;
    localparam mac_addr_t A_ACC0 = 4'hA;
    localparam mac_addr_t A_RND_HI = 4'hB;
    localparam mac_addr_t A_RND_LO = 4'hC;

    // Writable bits and reset values
    localparam mac_byte_t CFG_WMASK = 8'h3F;
    localparam mac_byte_t CFG_RST = 8'h00;
    localparam mac_byte_t FLAGS_WMASK = 8'h0F;
    localparam mac_byte_t FLAGS_RST = 8'h04;

    // Top byte edges for hard overflow
    localparam mac_byte_t TOP_POS = 8'h7F;
    localparam mac_byte_t TOP_NEG = 8'h80;

    // Rounding constants
    localparam mac_word_t RND_HALF = 16'h8000;
    localparam mac_word_t SAT_POS = 16'h7FFF;
    localparam mac_word_t SAT_NEG = 16'h8000;

    typedef struct packed {
        logic [1:0] unused;
        logic shift_go;
        logic shift_direction;
        logic clear_accumulator;
        logic saturate_enable;
        logic fractional_format_sel;
        logic multiply_only_sel;
    } mac_cfg_t;

    typedef struct packed {
        logic [3:0] unused;
        logic hard_overflow_flag;
        logic zero_flag;
        logic soft_overflow_flag;
        logic negative_flag;
    } mac_flags_t;

endpackage : mac_pkg

// File: mac_round.sv
// Purpose: Unbiased rounding of accumulator bits 31..16 with optional saturation
// Assumes: Purely combinational, caller registers the result
// Notes: Never touches the accumulator
`timescale 1ns/100ps
`default_nettype none
module mac_round (
    input wire mac_pkg::mac_acc_t acc,
    input wire logic sat_en,
    output logic [mac_pkg::OP_W-1:0] rnd
);
    import mac_pkg::*;

    mac_word_t win;
    mac_word_t frac;
    logic up;
    logic [OP_W:0] sum;
    logic ext_ok;
    logic ovf;

    assign win = acc[RND_LO +: OP_W];
    assign frac = acc[OP_W-1:0];
    assign up = (frac > RND_HALF) || ((frac == RND_HALF) && win[0]);
    assign sum = {win[OP_W-1], win} + {{OP_W{1'b0}}, up};
    assign ext_ok = (&acc[ACC_W-1:SIGN_LO]) || !(|acc[ACC_W-1:SIGN_LO]);
    assign ovf = !ext_ok || (sum[OP_W] != sum[OP_W-1]);

    always_comb begin
        if (sat_en && ovf) begin
            rnd = acc[ACC_W-1] ? SAT_NEG : SAT_POS;
        end else begin
            rnd = sum[OP_W-1:0];
        end
    end

endmodule : mac_round
`default_nettype wire

// File: mac_host_model.sv
// Purpose: Host core model driving the engine's byte registers
// Assumes: Signals change by non-blocking assignment after a rising edge
// Notes: Read data taken in the cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module mac_host_model (
    input wire logic clk,
    output mac_pkg::mac_addr_t addr,
    output mac_pkg::mac_byte_t wdata,
    output logic wr,
    output logic rd,
    input wire mac_pkg::mac_byte_t rdata
);
    import mac_pkg::*;
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic wr_reg(input mac_addr_t a, input mac_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input mac_addr_t a, output mac_byte_t d);
        @(posedge clk);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask : idle
    task automatic op(input mac_word_t a, input mac_word_t b);
        wr_reg(A_OP1_HI, a[15:8]);
        wr_reg(A_OP1_LO, a[7:0]);
        wr_reg(A_OP2_HI, b[15:8]);
        wr_reg(A_OP2_LO, b[7:0]);
    endtask : op
    task automatic load(input mac_acc_t v);
        for (int i = 0; i < ACC_BYTES; i++) begin
            wr_reg(A_ACC_TOP + 4'(i), v[ACC_W - 1 - BYTE_W * i -: BYTE_W]);
        end
    endtask : load
endmodule : mac_host_model
`default_nettype wire

// File: tb_mac_engine.sv
// Purpose: Self-checking bench of the multiply-accumulate engine
// Assumes: Host model drives the register port
// Notes: Expected state kept by bench functions
`timescale 1ns/100ps
`default_nettype none
module tb_mac_engine;
    import mac_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    mac_addr_t addr;
    mac_byte_t wdata;
    mac_byte_t rdata;
    mac_byte_t b8;
    logic wr;
    logic rd;
    int n_errors = 0;
    int comparisons = 0;
    mac_acc_t e_acc = '0;
    mac_flags_t e_flg = FLAGS_RST;
    mac_word_t e_rnd = '0;
    mac_acc_t rv[7] = '{40'h00_1235_8000, 40'h00_1234_8000, 40'h00_1234_8001,
        40'h00_1234_7FFF, 40'h00_7FFF_8000, 40'hFF_0000_0000, 40'h01_0000_0000};
    always #4 clk = ~clk;
    mac_engine uut (.SYS_CLK(clk), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata));
    mac_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    function automatic mac_word_t f_rnd(input mac_acc_t a, input logic sat);
        logic up;
        logic ovf;
        up = a[15:0] > RND_HALF || (a[15:0] == RND_HALF && a[16]);
        ovf = a[39:31] != {9{a[39]}} || (up && a[31:16] == SAT_POS);
        if (sat && ovf) return a[39] ? SAT_NEG : SAT_POS;
        return a[31:16] + 16'(up);
    endfunction : f_rnd
    function automatic mac_acc_t f_prod(input mac_word_t a, input mac_word_t b, input logic fm);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        return {{8{p[31]}}, p} << fm;
    endfunction : f_prod
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input mac_acc_t seen, input mac_acc_t exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rchk(input mac_addr_t a, input mac_acc_t exp);
        host.rd_reg(a, b8);
        chk(b8, exp);
    endtask : rchk
    task automatic chk_all();
        for (int i = 0; i < ACC_BYTES; i++) begin
            rchk(A_ACC_TOP + 4'(i), e_acc[39 - 8 * i -: 8]);
        end
        rchk(A_FLAGS, e_flg);
        rchk(A_RND_HI, e_rnd[15:8]);
        rchk(A_RND_LO, e_rnd[7:0]);
    endtask : chk_all
    task automatic ld(input mac_acc_t v, input logic sat);
        host.wr_reg(A_CFG, {5'h0, sat, 2'b00});
        host.load(v);
        e_acc = v;
        e_rnd = f_rnd(v, sat);
    endtask : ld
    task automatic exp_op(input mac_cfg_t c, input mac_word_t a, input mac_word_t b);
        mac_acc_t n;
        if (c.clear_accumulator) begin
            e_acc = '0;
            e_flg = '0;
        end
        n = (c.multiply_only_sel ? '0 : e_acc) + f_prod(a, b, c.fractional_format_sel);
        if (!c.multiply_only_sel && {e_acc[39:32], n[39:32]} inside {16'h7F80, 16'h807F})
            e_flg.hard_overflow_flag = 1'b1;
        e_flg.zero_flag = n == '0;
        e_flg.soft_overflow_flag = n[39:31] != {9{n[39]}};
        e_flg.negative_flag = n[39];
        e_acc = n;
        e_rnd = f_rnd(n, c.saturate_enable);
    endtask : exp_op
    task automatic mac_step(input mac_cfg_t c, input mac_word_t a, input mac_word_t b,
        input int k);
        mac_acc_t o;
        mac_word_t r;
        o = e_acc;
        r = e_rnd;
        host.wr_reg(A_CFG, c);
        host.op(a, b);
        exp_op(c, a, b);
        host.idle(k == 0 ? 0 : (k == 2 ? 3 : 2));
        host.rd_reg(k % 3 == 0 ? A_ACC0 : A_RND_LO, b8);
        case (k)
            0: chk(b8, o[7:0]);
            1: chk(b8, r[7:0]);
            2: chk(b8, e_rnd[7:0]);
            default: chk(b8, e_acc[7:0]);
        endcase
        host.idle(3);
        chk_all();
    endtask : mac_step
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(24650));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk(A_CFG, CFG_RST);
        host.wr_reg(A_RND_HI, 8'hFF);
        host.wr_reg(4'hE, 8'h5A);
        rchk(4'hE, 8'h00);
        chk_all();
        foreach (rv[i]) begin
            for (int s = 0; s < 2; s++) begin
                ld(rv[i], s[0]);
                chk_all();
            end
        end
        ld(40'h7F_FFFF_FFFF, 1'b0);
        mac_step(8'h00, 16'h0001, 16'h0001, 0);
        mac_step(8'h01, 16'h0003, 16'h0005, 3);
        host.wr_reg(A_FLAGS, 8'h00);
        e_flg = '0;
        ld(40'h80_0000_0000, 1'b0);
        mac_step(8'h00, 16'hFFFF, 16'h0001, 2);
        ld(40'h40_8844_2211, 1'b0);
        host.wr_reg(A_CFG, 8'h20);
        host.idle(2);
        e_acc = e_acc << 1;
        e_rnd = f_rnd(e_acc, 1'b0);
        rchk(A_CFG, 8'h00);
        chk_all();
        host.wr_reg(A_CFG, 8'h30);
        host.wr_reg(A_CFG, 8'h30);
        host.idle(3);
        e_acc = {{2{e_acc[39]}}, e_acc[39:2]};
        e_rnd = f_rnd(e_acc, 1'b0);
        rchk(A_CFG, 8'h10);
        chk_all();
        host.wr_reg(A_CFG, 8'h0A);
        host.op(16'h4000, 16'h2000);
        host.wr_reg(A_OP2_HI, 8'hE0);
        host.wr_reg(A_OP2_LO, 8'h00);
        exp_op(8'h0A, 16'h4000, 16'h2000);
        exp_op(8'h02, 16'h4000, 16'hE000);
        host.idle(3);
        rchk(A_CFG, 8'h02);
        chk_all();
        mac_step(8'h01, 16'h1234, 16'hFEDC, 1);
        @(posedge clk);
        ce <= 1'b0;
        host.wr_reg(A_ACC0, ~e_acc[7:0]);
        host.idle(1);
        ce <= 1'b1;
        chk_all();
        for (int i = 0; i < 48; i++) begin
            mac_step({4'h0, i[3:0]}, 16'($urandom), 16'($urandom), $urandom_range(3));
        end
        stop_test();
    end
endmodule : tb_mac_engine
`default_nettype wire
